// ### hdl/tss_pkg.sv
// Constants, register map and state codes of the testable safety sensor monitor.
// Assumes one 20 MHz system clock and an APB register bus with 32-bit data.
package tss_pkg;
  // Timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_PERIOD_US  = 1000;
  localparam int TICK_CYCLES     = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int WINDOW_MAX_MS   = 150;
  localparam int WINDOW_RESET_MS = 10;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WINDOW = 8'h04;
  localparam logic [7:0] REG_TICK   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DIAG   = 8'h10;

  // Control bit positions
  localparam int CTRL_ACTIVATE   = 0;
  localparam int CTRL_AUTO_RST   = 1;
  localparam int CTRL_START_RST  = 2;
  localparam int CTRL_MANUAL_UNS = 3;
  localparam int CTRL_INT_INHIB  = 4;
  localparam int CTRL_WIDTH      = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Diagnostic words
  localparam logic [15:0] DIAG_IDLE     = 16'h0000;
  localparam logic [15:0] DIAG_RUN      = 16'h8000;
  localparam logic [15:0] DIAG_INHIBIT  = 16'h8001;
  localparam logic [15:0] DIAG_DEMAND   = 16'h8002;
  localparam logic [15:0] DIAG_TEST     = 16'h8010;
  localparam logic [15:0] DIAG_PARAM    = 16'hc000;
  localparam logic [15:0] DIAG_FEEDBACK = 16'hc001;
  localparam logic [15:0] DIAG_NORESP   = 16'hc002;
  localparam logic [15:0] DIAG_STATIC   = 16'hc003;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_INHIBIT   = 4'b0001,
    ST_RUN       = 4'b0010,
    ST_DEMAND    = 4'b0011,
    ST_TEST_OFF  = 4'b0100,
    ST_TEST_ON   = 4'b0101,
    ST_ERR_PARAM = 4'b1000,
    ST_ERR_FDBK  = 4'b1001,
    ST_ERR_RESP  = 4'b1010,
    ST_ERR_RESET = 4'b1011
  } tss_state_t;
endpackage

// ### hdl/tss_monitor.sv
// Testable single-channel protective sensor monitor with APB register access.
// Assumes sensor, reset and test request pins are synchronous to clock.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - On test request drive sensor test line low and start the window.
// - Sensor input falling during test restarts the window timing.
// - After switch-off, raise test line; sensor returns high; supervision ends.
// - Safe release stays high throughout the test sequence.
// - Window expiry without delayed sensor feedback enters error.
// - Test with no sensor response enters error.
// - Reset input held high at activation without auto restart enters error.
// - Implausible test window enters parameter error with code C000.
// - Any error forces safe release low until a valid reset.
// - Without auto restart only a rising reset edge clears error or inhibit.
// - Optional inhibit after field interruption, released by reset edge.
// - Optional inhibit after activation, released by reset edge.
// - Activate low forces idle from any state, highest priority.
// - Test window is 0 to 150 ms, default 10 ms.
// - Manual test unsupported allows retest without manual switching sequence.
// - Test passed rises on success; low while active, failed or not run.
module tss_monitor
  import tss_pkg::*;
#(
  parameter int TICK_DEFAULT = tss_pkg::TICK_CYCLES
)(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor side
  input  wire logic        sensorSwitchIn,
  output logic             sensorTestDrive,
  // Application side
  input  wire logic        testRequest,
  input  wire logic        resetIn,
  output logic             safeReleaseOut,
  output logic             testPassed,
  output logic             testAllowed,
  output logic             readyOut,
  output logic             errorOut,
  output logic      [15:0] diagnosticWord
);
  import tss_pkg::*;

  logic [CTRL_WIDTH-1:0] ctrlQ;
  logic [15:0]           windowQ;
  logic [31:0]           tickQ;
  logic [31:0]           tickCntQ;
  logic [15:0]           winCntQ;
  logic                  msTick;
  logic                  timeout;
  logic                  windowOk;
  logic                  resetPrevQ;
  logic                  testReqPrevQ;
  logic                  resetRise;
  logic                  resetOk;
  logic                  testReqRise;
  logic                  manualLowQ;
  logic                  manualDoneQ;
  logic                  activate;
  logic                  autoRst;
  logic                  apbWrite;
  logic                  apbSetup;
  logic                  isErrD;
  logic                  isErrQ;
  tss_state_t            stateQ;
  tss_state_t            stateD;
  logic [15:0]           diagD;

  assign activate    = ctrlQ[CTRL_ACTIVATE];
  assign autoRst     = ctrlQ[CTRL_AUTO_RST];
  assign windowOk    = windowQ <= 16'(WINDOW_MAX_MS);
  assign resetRise   = resetIn & ~resetPrevQ;
  // Auto restart accepts a reset level, otherwise only an edge counts
  assign resetOk     = autoRst ? resetIn : resetRise;
  assign testReqRise = testRequest & ~testReqPrevQ;
  assign timeout     = winCntQ >= windowQ;
  assign isErrD      = stateD[3];
  assign isErrQ      = stateQ[3];

  // APB slave: no wait state, pready is registered from the setup phase, so every bus output comes from a flop
  assign apbSetup = psel & ~penable & ~pready;
  assign apbWrite = psel & penable & pready & pwrite;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= apbSetup;
      pslverr <= 1'b0;
      if (apbSetup)
      begin
        prdata <= 32'h0;
        case (paddr)
          REG_CTRL:   prdata <= {27'h0, ctrlQ};
          REG_WINDOW: prdata <= {16'h0, windowQ};
          REG_TICK:   prdata <= tickQ;
          REG_STATUS: prdata <= {22'h0, stateQ, errorOut, readyOut, testAllowed, testPassed,
                                 sensorTestDrive, safeReleaseOut};
          REG_DIAG:   prdata <= {16'h0, diagnosticWord};
          default:    pslverr <= 1'b1;
        endcase
        if (pwrite && paddr != REG_CTRL && paddr != REG_WINDOW && paddr != REG_TICK)
          pslverr <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrlQ   <= CTRL_RESET;
      windowQ <= 16'(WINDOW_RESET_MS);
      tickQ   <= 32'(TICK_DEFAULT);
    end
    else if (apbWrite)
    begin
      case (paddr)
        REG_CTRL:   ctrlQ   <= pwdata[CTRL_WIDTH-1:0];
        REG_WINDOW: windowQ <= pwdata[15:0];
        REG_TICK:   tickQ   <= (pwdata == 32'h0) ? 32'h1 : pwdata;
        default:    ctrlQ   <= ctrlQ;
      endcase
    end
  end

  // Input edge detection
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      resetPrevQ   <= 1'b0;
      testReqPrevQ <= 1'b0;
    end
    else
    begin
      resetPrevQ   <= resetIn;
      testReqPrevQ <= testRequest;
    end
  end

  // Window timing restarts on every state change, so each phase gets a full window
  assign msTick = tickCntQ >= tickQ - 32'h1;

  always_ff @(posedge clock)
  begin
    if (rst || stateD != stateQ)
    begin
      tickCntQ <= 32'h0;
      winCntQ  <= 16'h0;
    end
    else if (msTick)
    begin
      tickCntQ <= 32'h0;
      if (winCntQ != 16'hffff)
        winCntQ <= winCntQ + 16'h1;
    end
    else
      tickCntQ <= tickCntQ + 32'h1;
  end

  // Manual switching sequence seen while in a test error
  always_ff @(posedge clock)
  begin
    if (rst || !(stateQ == ST_ERR_FDBK || stateQ == ST_ERR_RESP))
    begin
      manualLowQ  <= 1'b0;
      manualDoneQ <= 1'b0;
    end
    else
    begin
      if (!sensorSwitchIn)
        manualLowQ <= 1'b1;
      if (manualLowQ && sensorSwitchIn)
        manualDoneQ <= 1'b1;
    end
  end

  always_comb
  begin
    stateD = stateQ;
    if (!activate)
      stateD = ST_IDLE;
    else if (!windowOk)
      stateD = ST_ERR_PARAM;
    else
    begin
      case (stateQ)
        ST_IDLE:
          if (resetIn && !autoRst)
            stateD = ST_ERR_RESET;
          else if (ctrlQ[CTRL_START_RST] && sensorSwitchIn)
            stateD = ST_RUN;
          else
            stateD = ST_INHIBIT;
        ST_INHIBIT:
          if (sensorSwitchIn && resetOk)
            stateD = ST_RUN;
        ST_RUN:
          if (!sensorSwitchIn)
            stateD = ST_DEMAND;
          else if (testReqRise)
            stateD = ST_TEST_OFF;
        ST_DEMAND:
          if (sensorSwitchIn && (!ctrlQ[CTRL_INT_INHIB] || resetOk))
            stateD = ST_RUN;
        ST_TEST_OFF:
          if (!sensorSwitchIn)
            stateD = ST_TEST_ON;
          else if (timeout)
            stateD = ST_ERR_RESP;
        ST_TEST_ON:
          if (sensorSwitchIn)
            stateD = ST_RUN;
          else if (timeout)
            stateD = ST_ERR_FDBK;
        ST_ERR_FDBK, ST_ERR_RESP:
          if (sensorSwitchIn && resetOk && (ctrlQ[CTRL_MANUAL_UNS] || manualDoneQ))
            stateD = ST_RUN;
        ST_ERR_PARAM, ST_ERR_RESET:
          if (sensorSwitchIn && resetOk)
            stateD = ST_RUN;
        default:
          stateD = ST_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (stateD)
      ST_IDLE:      diagD = DIAG_IDLE;
      ST_INHIBIT:   diagD = DIAG_INHIBIT;
      ST_RUN:       diagD = DIAG_RUN;
      ST_DEMAND:    diagD = DIAG_DEMAND;
      ST_TEST_OFF:  diagD = DIAG_TEST;
      ST_TEST_ON:   diagD = DIAG_TEST;
      ST_ERR_PARAM: diagD = DIAG_PARAM;
      ST_ERR_FDBK:  diagD = DIAG_FEEDBACK;
      ST_ERR_RESP:  diagD = DIAG_NORESP;
      default:      diagD = DIAG_STATIC;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      stateQ <= ST_IDLE;
    else
      stateQ <= stateD;
  end

  // Outputs follow the next state so they line up with stateQ
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      safeReleaseOut  <= 1'b0;
      sensorTestDrive <= 1'b1;
      testPassed      <= 1'b0;
      testAllowed     <= 1'b0;
      readyOut        <= 1'b0;
      errorOut        <= 1'b0;
      diagnosticWord  <= DIAG_IDLE;
    end
    else
    begin
      safeReleaseOut  <= stateD == ST_RUN || stateD == ST_TEST_OFF
                         || stateD == ST_TEST_ON;
      sensorTestDrive <= stateD != ST_TEST_OFF;
      testAllowed     <= stateD == ST_RUN;
      readyOut        <= activate;
      errorOut        <= isErrD;
      diagnosticWord  <= diagD;
      if (stateQ == ST_TEST_ON && stateD == ST_RUN)
        testPassed <= 1'b1;
      else if (stateD != ST_RUN && stateD != ST_DEMAND)
        testPassed <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence testEnter;
    stateQ == ST_RUN && stateD == ST_TEST_OFF;
  endsequence
  sequence switchOff;
    stateQ == ST_TEST_OFF && stateD == ST_TEST_ON;
  endsequence

  test_start_a: assert property (testEnter |=> !sensorTestDrive && winCntQ == 16'h0)
    else $error("Test start did not drop the test line");
  window_restart_a: assert property (switchOff |=> sensorTestDrive && winCntQ == 16'h0)
    else $error("Window not restarted on sensor switch-off");
  test_end_a: assert property ($rose(sensorTestDrive) && !isErrQ
    |-> stateQ == ST_TEST_ON || stateQ == ST_IDLE)
    else $error("Test line rose outside the switch-on phase");
  hold_release_a: assert property (stateQ == ST_TEST_OFF || stateQ == ST_TEST_ON
    |-> safeReleaseOut)
    else $error("Release dropped during test");
  feedback_err_a: assert property (stateQ == ST_TEST_ON && timeout && !sensorSwitchIn
    && activate && windowOk |=> errorOut && diagnosticWord == DIAG_FEEDBACK)
    else $error("Missing feedback not flagged");
  no_resp_a: assert property (stateQ == ST_TEST_OFF && timeout && sensorSwitchIn
    && activate && windowOk |=> errorOut && diagnosticWord == DIAG_NORESP)
    else $error("Missing response not flagged");
  static_reset_a: assert property (stateQ == ST_IDLE && activate && windowOk && resetIn
    && !autoRst |=> diagnosticWord == DIAG_STATIC)
    else $error("Static reset not flagged");
  param_err_a: assert property (activate && !windowOk |=> errorOut
    && diagnosticWord == DIAG_PARAM && !safeReleaseOut)
    else $error("Bad window not flagged");
  safe_error_a: assert property (errorOut |-> !safeReleaseOut && !testPassed)
    else $error("Release high in error");
  edge_only_a: assert property (isErrQ && activate && !autoRst && !resetRise
    |=> errorOut)
    else $error("Error left without a reset edge");
  idle_force_a: assert property (!activate |=> stateQ == ST_IDLE && !safeReleaseOut
    && !errorOut)
    else $error("Deactivation did not force idle");
  test_pass_a: assert property ($rose(testPassed) |-> $past(stateQ) == ST_TEST_ON
    && stateQ == ST_RUN)
    else $error("Pass flag without completed test");
endmodule
`default_nettype wire

// ### dv/tss_sensor_model.sv
// Behavioural single-beam protective sensor facing the monitor's test line.
// Assumes the test line and the bench commands are synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module tss_sensor_model (
  // Clock
  input  wire logic       clock,
  // Bench commands
  input  wire logic [7:0] respDelay,
  input  wire logic       ignoreTest,
  input  wire logic       stuckLow,
  input  wire logic       fieldBlocked,
  // Sensor pins
  input  wire logic       testDrive,
  output logic            switchOut
);
  logic       lastQ = 1'b1;
  logic       beamQ = 1'b1;
  logic [7:0] cntQ  = 8'h00;
  // Output follows the test line respDelay plus two cycles later, far inside 150 ms
  always_ff @(posedge clock)
  begin
    lastQ <= testDrive;
    if (testDrive !== lastQ)
      cntQ <= 8'h00;
    else if (cntQ != 8'hff)
      cntQ <= cntQ + 8'h01;
    if (testDrive === lastQ && cntQ >= respDelay && !ignoreTest && !(stuckLow && testDrive))
      beamQ <= (testDrive !== 1'b0);
  end
  // Blocking the field overrides the beam, like a real interruption
  assign switchOut = beamQ & ~fieldBlocked;
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench of the safety sensor monitor, APB master and sensor model.
// Assumes a short ms tick (20 cycles) so windows stay a few hundred cycles.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import tss_pkg::*;
  logic clock = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00, respDelay = 8'h03;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic rdErr, sensorSwitchIn, sensorTestDrive, testRequest = 1'b0, resetIn = 1'b0;
  logic safeReleaseOut, testPassed, testAllowed, readyOut, errorOut;
  logic ignoreTest = 1'b0, stuckLow = 1'b0, fieldBlocked = 1'b0;
  logic [15:0] diagnosticWord;
  int miscompares = 0, comparisons = 0, cycles = 0;

  tss_monitor #(.TICK_DEFAULT(20)) i_dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sensorSwitchIn(sensorSwitchIn),
    .sensorTestDrive(sensorTestDrive), .testRequest(testRequest), .resetIn(resetIn),
    .safeReleaseOut(safeReleaseOut), .testPassed(testPassed), .testAllowed(testAllowed),
    .readyOut(readyOut), .errorOut(errorOut), .diagnosticWord(diagnosticWord));
  tss_sensor_model i_sensor (.clock(clock), .respDelay(respDelay), .ignoreTest(ignoreTest),
    .stuckLow(stuckLow), .fieldBlocked(fieldBlocked), .testDrive(sensorTestDrive),
    .switchOut(sensorSwitchIn));

  initial
  begin
    forever #25 clock = ~clock;
  end
  // Hang guard: the whole run needs well under 5000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; the access phase is held until pready is seen high
  // Only the hang guard ends a wait that never gets an answer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitDiag(input logic [15:0] d, input int lim);
    int n;
    n = 0;
    while (diagnosticWord !== d && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    `CHK(diagnosticWord, d)
  endtask

  // Edge-detected inputs get one-cycle pulses
  task automatic pulse(input bit isTest);
    @(posedge clock);
    if (isTest) testRequest <= 1'b1; else resetIn <= 1'b1;
    @(posedge clock);
    if (isTest) testRequest <= 1'b0; else resetIn <= 1'b0;
  endtask

  task automatic sResetAndBus();
    `CHK(safeReleaseOut, 1'b0)
    `CHK(sensorTestDrive, 1'b1)
    apb(1'b0, REG_WINDOW, 32'h0);
    `CHK(rdData[15:0], 16'(WINDOW_RESET_MS))
    apb(1'b0, 8'h14, 32'h0);
    `CHK({rdErr, rdData}, {1'b1, 32'h0})
    apb(1'b1, REG_STATUS, 32'hffff_ffff);
    `CHK(rdErr, 1'b1)
  endtask

  task automatic sActivate();
    apb(1'b1, REG_CTRL, 32'h1);
    waitDiag(DIAG_INHIBIT, 10);
    `CHK(safeReleaseOut, 1'b0)
    pulse(1'b0);
    waitDiag(DIAG_RUN, 10);
    `CHK({safeReleaseOut, testAllowed, readyOut}, 3'b111)
  endtask

  // Each phase takes 18 cycles against a 20-cycle window: passes only if restarted
  task automatic sGoodTest();
    int n;
    apb(1'b1, REG_WINDOW, 32'h1);
    respDelay <= 8'd15;
    pulse(1'b1);
    @(posedge clock);
    `CHK(sensorTestDrive, 1'b0)
    for (n = 0; n < 100 && diagnosticWord !== DIAG_RUN; n++)
    begin
      `CHK(safeReleaseOut, 1'b1)
      `CHK(testPassed, 1'b0)
      @(posedge clock);
    end
    `CHK({testPassed, errorOut, sensorTestDrive}, 3'b101)
    respDelay <= 8'd3;
    apb(1'b1, REG_WINDOW, 32'd10);
  endtask

  // Silent sensor, reset level held through the error, then a clean edge
  task automatic sNoResponse();
    apb(1'b1, REG_CTRL, 32'h9);
    ignoreTest <= 1'b1;
    resetIn <= 1'b1;
    pulse(1'b1);
    waitDiag(DIAG_NORESP, 400);
    `CHK({errorOut, safeReleaseOut, testPassed}, 3'b100)
    ignoreTest <= 1'b0;
    repeat (20) @(posedge clock);
    `CHK(diagnosticWord, DIAG_NORESP)
    resetIn <= 1'b0;
    pulse(1'b0);
    waitDiag(DIAG_RUN, 20);
    `CHK(safeReleaseOut, 1'b1)
  endtask

  task automatic sStuck();
    stuckLow <= 1'b1;
    pulse(1'b1);
    waitDiag(DIAG_FEEDBACK, 400);
    `CHK(safeReleaseOut, 1'b0)
    stuckLow <= 1'b0;
    repeat (10) @(posedge clock);
    pulse(1'b0);
    waitDiag(DIAG_RUN, 20);
  endtask

  task automatic sInterrupt();
    apb(1'b1, REG_CTRL, 32'h19);
    fieldBlocked <= 1'b1;
    waitDiag(DIAG_DEMAND, 10);
    fieldBlocked <= 1'b0;
    repeat (5) @(posedge clock);
    `CHK(diagnosticWord, DIAG_DEMAND)
    `CHK(safeReleaseOut, 1'b0)
    pulse(1'b0);
    waitDiag(DIAG_RUN, 10);
  endtask

  task automatic sParamAndStatic();
    apb(1'b1, REG_WINDOW, 32'd151);
    waitDiag(DIAG_PARAM, 10);
    `CHK({errorOut, safeReleaseOut}, 2'b10)
    apb(1'b1, REG_WINDOW, 32'd150);
    pulse(1'b0);
    waitDiag(DIAG_RUN, 10);
    apb(1'b1, REG_CTRL, 32'h0);
    waitDiag(DIAG_IDLE, 10);
    resetIn <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    waitDiag(DIAG_STATIC, 10);
    `CHK(safeReleaseOut, 1'b0)
    resetIn <= 1'b0;
    pulse(1'b0);
    repeat (5) @(posedge clock);
    `CHK(errorOut, 1'b0)
  endtask

  // Start without inhibit, then a test error left on a reset level after a manual sequence
  task automatic sAutoRestart();
    apb(1'b1, REG_WINDOW, 32'd2);
    apb(1'b1, REG_CTRL, 32'h0);
    waitDiag(DIAG_IDLE, 10);
    apb(1'b1, REG_CTRL, 32'h7);
    waitDiag(DIAG_RUN, 10);
    `CHK({safeReleaseOut, readyOut}, 2'b11)
    ignoreTest <= 1'b1;
    pulse(1'b1);
    waitDiag(DIAG_NORESP, 100);
    resetIn <= 1'b1;
    ignoreTest <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK({errorOut, diagnosticWord}, {1'b1, DIAG_NORESP})
    fieldBlocked <= 1'b1;
    repeat (3) @(posedge clock);
    fieldBlocked <= 1'b0;
    waitDiag(DIAG_RUN, 10);
    `CHK(safeReleaseOut, 1'b1)
    resetIn <= 1'b0;
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    sResetAndBus();
    sActivate();
    sGoodTest();
    sNoResponse();
    sStuck();
    sInterrupt();
    sParamAndStatic();
    sAutoRestart();
    summarize();
  end
endmodule
`default_nettype wire
